// file: gp_defines.svh
// register offsets, reset values and pin layout constants for the gpio bank
`ifndef GP_DEFINES_SVH
`define GP_DEFINES_SVH

// register byte offsets
`define GP_OFS_DIR       8'h00
`define GP_OFS_OUT       8'h04
`define GP_OFS_LEVEL     8'h08
`define GP_OFS_DRIVE     8'h0C
`define GP_OFS_PULLDIR   8'h10
`define GP_OFS_EDGE      8'h14
`define GP_OFS_IRQ_EN    8'h18
`define GP_OFS_IRQ_STAT  8'h1C
`define GP_OFS_ALT       8'h20

// pins that exist in the bank and pins that carry an alternate function
`define GP_PIN_MASK      8'hFE
`define GP_ALT_MASK      8'hD0
`define GP_TIMER_BIT     6

// reset values
`define GP_RST_DIR       8'h00
`define GP_RST_OUT       8'hFE
`define GP_RST_DRIVE     8'h00
`define GP_RST_PULLDIR   8'hFE
`define GP_RST_EDGE      8'h00
`define GP_RST_IRQ_EN    8'h00
`define GP_RST_ALT       8'h00
`define GP_RST_ZERO      8'h00
`define GP_RST_PIN_IDLE  8'hFE // pins idle high under their reset pull-ups

`endif

// file: gp_pkg.sv
// types shared by the gpio bank modules
package gp_pkg;

    typedef logic [7:0] gp_byte_type;

    // which register an address selects
    typedef enum logic [3:0] {
        GP_SEL_NONE,
        GP_SEL_DIR,
        GP_SEL_OUT,
        GP_SEL_LEVEL,
        GP_SEL_DRIVE,
        GP_SEL_PULLDIR,
        GP_SEL_EDGE,
        GP_SEL_IRQ_EN,
        GP_SEL_IRQ_STAT,
        GP_SEL_ALT
    } gp_sel_type;

endpackage

// file: gp_edge_if.sv
// carrier between the pin sampler and the register core
`timescale 1ns/1ns
interface gp_edge_if;
    logic [7:0] level;
    logic [7:0] rise;
    logic [7:0] fall;

    modport sampler
    (
        output level,
        output rise,
        output fall
    );

    modport core
    (
        input level,
        input rise,
        input fall
    );
endinterface

// file: gp_pin_sampler.sv
// two-stage pin synchroniser with rising and falling edge detection
`timescale 1ns/1ns
`include "gp_defines.svh"
module gp_pin_sampler
    import gp_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] pad_in,
    gp_edge_if.sampler edge_bus
);

    logic [7:0] meta_q;
    logic [7:0] meta_d;
    logic [7:0] sync_q;
    logic [7:0] sync_d;
    logic [7:0] prev_q;
    logic [7:0] prev_d;

    // next values: first stage feeds only the second
    always_comb
    begin
        meta_d = pad_in; // R15
        sync_d = meta_q; // R15
        prev_d = sync_q;
    end

    // synchroniser and previous-level registers; reset to the idle level, no false edge
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta_q <= `GP_RST_PIN_IDLE;
            sync_q <= `GP_RST_PIN_IDLE;
            prev_q <= `GP_RST_PIN_IDLE;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // edges seen on the synchronised level only
    assign edge_bus.level = sync_q & `GP_PIN_MASK;
    assign edge_bus.rise = sync_q & ~prev_q & `GP_PIN_MASK;
    assign edge_bus.fall = ~sync_q & prev_q & `GP_PIN_MASK;

endmodule

// file: gp_bank.sv
// seven-pin general purpose i/o bank with edge interrupts and wake-up
`timescale 1ns/1ns
`include "gp_defines.svh"

// Summary of operation
// R01: The bank offers seven bidirectional pins, each controlled on its own.
// R02: A pin used as a port can float, pull weakly up or pull weakly down.
// R03: After reset every pin is an input with its weak pull-up on.
// R04: Each pin can raise an interrupt on a chosen rising or falling edge.
// R05: In stop mode any enabled pin interrupt wakes the device.
// R06: A direction register makes each pin an input or an output.
// R07: An output pin drives the level held in its output latch bit.
// R08: Reading the output latch returns the latch whatever the direction.
// R09: The sampled level register is read-only and shows each pin level.
// R10: A drive strength bit picks the low or high drive for an output pin.
// R11: On an input pin the output latch bit turns the weak pull on or off.
// R12: A pull direction bit makes the enabled weak pull go up or down.
// R13: Three pins also carry an alternate function beside the port function.
// R14: The timer pin can follow the timer channel zero logic, not the latch.
// R15: Pin levels pass two synchronising flops before any logic uses them.
// R16: Each pin has a sticky flag set on its edge, and requests only if enabled.
module gp_bank
    import gp_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe,
    output logic [7:0] pad_pull_en,
    output logic [7:0] pad_pull_up,
    output logic [7:0] pad_drive_hi,
    input wire logic [7:0] alt_out,
    input wire logic [7:0] alt_oe,
    output logic [7:0] alt_in,
    input wire logic stop_mode,
    output logic irq,
    output logic wake_req
);

    // the decoder compares against 8-bit offsets
    if (ADDR_W < 8)
    begin : g_bad_addr
        $error("gp_bank: ADDR_W must be at least 8");
    end

    // pin and shared-pin layout of the byte
    localparam gp_byte_type PIN_MASK = `GP_PIN_MASK;
    localparam gp_byte_type ALT_MASK = `GP_ALT_MASK;

    // number of set bits in a mask
    function automatic int count_pins(input gp_byte_type m);
        int n;
        n = 0;
        for (int i = 0; i < 8; i++)
        begin
            n = n + int'(m[i]);
        end
        return n;
    endfunction

    // the layout must give seven pins and three shared ones,
    // the timer's pin among the shared
    if (count_pins(PIN_MASK) != 7)
    begin : g_bad_pins
        $error("gp_bank: the bank must have seven pins"); // R01
    end
    if ((ALT_MASK & ~PIN_MASK) != 8'h00)
    begin : g_bad_alt
        $error("gp_bank: shared pins must be bank pins"); // R13
    end
    if (count_pins(ALT_MASK) != 3)
    begin : g_bad_alt_count
        $error("gp_bank: three pins carry an alternate function"); // R13
    end
    if (ALT_MASK[`GP_TIMER_BIT] != 1'b1)
    begin : g_bad_timer
        $error("gp_bank: timer pin must be a shared pin"); // R14
    end

    gp_edge_if edge_bus();

    // pin sampling and edge detection
    gp_pin_sampler u_sampler
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .pad_in(pad_in),
        .edge_bus(edge_bus.sampler)
    );

    // map an address onto a register selector
    function automatic gp_sel_type decode(input logic [ADDR_W-1:0] addr);
        gp_sel_type sel;
        sel = GP_SEL_NONE;
        if ((addr >> 8) == '0)
        begin
            unique case (addr[7:0])
                `GP_OFS_DIR: sel = GP_SEL_DIR;
                `GP_OFS_OUT: sel = GP_SEL_OUT;
                `GP_OFS_LEVEL: sel = GP_SEL_LEVEL;
                `GP_OFS_DRIVE: sel = GP_SEL_DRIVE;
                `GP_OFS_PULLDIR: sel = GP_SEL_PULLDIR;
                `GP_OFS_EDGE: sel = GP_SEL_EDGE;
                `GP_OFS_IRQ_EN: sel = GP_SEL_IRQ_EN;
                `GP_OFS_IRQ_STAT: sel = GP_SEL_IRQ_STAT;
                `GP_OFS_ALT: sel = GP_SEL_ALT;
                default: sel = GP_SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    gp_byte_type dir_ctrl_reg_q;
    gp_byte_type dir_ctrl_reg_d;
    gp_byte_type out_latch_reg_q;
    gp_byte_type out_latch_reg_d;
    gp_byte_type drive_strength_sel_q;
    gp_byte_type drive_strength_sel_d;
    gp_byte_type pull_direction_sel_q;
    gp_byte_type pull_direction_sel_d;
    gp_byte_type edge_sel_q;
    gp_byte_type edge_sel_d;
    gp_byte_type irq_en_q;
    gp_byte_type irq_en_d;
    gp_byte_type irq_stat_q;
    gp_byte_type irq_stat_d;
    gp_byte_type alt_function_q;
    gp_byte_type alt_function_d;
    gp_byte_type rdata_q;
    gp_byte_type rdata_d;
    gp_byte_type edge_hit;
    gp_sel_type wr_sel;
    gp_sel_type rd_sel;
    logic stat_rd;
    gp_byte_type irq_pending;

    // one selector per strobe; no strobe selects nothing
    assign wr_sel = reg_wr ? decode(reg_addr) : GP_SEL_NONE;
    assign rd_sel = reg_rd ? decode(reg_addr) : GP_SEL_NONE;

    // a read of the flag register clears what it returns
    assign stat_rd = (rd_sel == GP_SEL_IRQ_STAT); // R16

    // configuration register writes; absent pins hold zero
    always_comb
    begin
        dir_ctrl_reg_d = dir_ctrl_reg_q;
        out_latch_reg_d = out_latch_reg_q;
        drive_strength_sel_d = drive_strength_sel_q;
        pull_direction_sel_d = pull_direction_sel_q;
        edge_sel_d = edge_sel_q;
        irq_en_d = irq_en_q;
        alt_function_d = alt_function_q;
        unique case (wr_sel)
            GP_SEL_DIR: dir_ctrl_reg_d = reg_wdata & `GP_PIN_MASK; // R06
            GP_SEL_OUT: out_latch_reg_d = reg_wdata & `GP_PIN_MASK; // R07
            GP_SEL_DRIVE: drive_strength_sel_d = reg_wdata & `GP_PIN_MASK; // R10
            GP_SEL_PULLDIR: pull_direction_sel_d = reg_wdata & `GP_PIN_MASK; // R12
            GP_SEL_EDGE: edge_sel_d = reg_wdata & `GP_PIN_MASK; // R04
            GP_SEL_IRQ_EN: irq_en_d = reg_wdata & `GP_PIN_MASK; // R16
            GP_SEL_ALT: alt_function_d = reg_wdata & `GP_ALT_MASK; // R13
            default: dir_ctrl_reg_d = dir_ctrl_reg_q;
        endcase
    end

    // configuration registers; reset leaves inputs with pull-ups on
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dir_ctrl_reg_q <= `GP_RST_DIR; // R03
            out_latch_reg_q <= `GP_RST_OUT; // R03
            drive_strength_sel_q <= `GP_RST_DRIVE;
            pull_direction_sel_q <= `GP_RST_PULLDIR; // R03
            edge_sel_q <= `GP_RST_EDGE;
            irq_en_q <= `GP_RST_IRQ_EN;
            alt_function_q <= `GP_RST_ALT;
        end
        else
        begin
            dir_ctrl_reg_q <= dir_ctrl_reg_d;
            out_latch_reg_q <= out_latch_reg_d;
            drive_strength_sel_q <= drive_strength_sel_d;
            pull_direction_sel_q <= pull_direction_sel_d;
            edge_sel_q <= edge_sel_d;
            irq_en_q <= irq_en_d;
            alt_function_q <= alt_function_d;
        end
    end

    // rise where the select bit is 1, fall where it is 0
    function automatic gp_byte_type pick_edges(input gp_byte_type up, input gp_byte_type down,
        input gp_byte_type sel);
        return (up & sel) | (down & ~sel);
    endfunction

    // selected edge per pin: 1 rising, 0 falling
    assign edge_hit = pick_edges(edge_bus.rise, edge_bus.fall, edge_sel_q) & PIN_MASK; // R04

    // sticky flags; a read clears what it returned, a new edge wins
    always_comb
    begin
        irq_stat_d = irq_stat_q;
        if (stat_rd)
        begin
            irq_stat_d = '0;
        end
        irq_stat_d = irq_stat_d | edge_hit; // R16
    end

    // interrupt flag register
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_stat_q <= `GP_RST_ZERO;
        end
        else
        begin
            irq_stat_q <= irq_stat_d;
        end
    end

    // read data mux; unmapped addresses read zero
    always_comb
    begin
        unique case (rd_sel)
            GP_SEL_DIR: rdata_d = dir_ctrl_reg_q;
            GP_SEL_OUT: rdata_d = out_latch_reg_q; // R08
            GP_SEL_LEVEL: rdata_d = edge_bus.level; // R09
            GP_SEL_DRIVE: rdata_d = drive_strength_sel_q;
            GP_SEL_PULLDIR: rdata_d = pull_direction_sel_q;
            GP_SEL_EDGE: rdata_d = edge_sel_q;
            GP_SEL_IRQ_EN: rdata_d = irq_en_q;
            GP_SEL_IRQ_STAT: rdata_d = irq_stat_q;
            GP_SEL_ALT: rdata_d = alt_function_q;
            default: rdata_d = `GP_RST_ZERO;
        endcase
    end

    // read data stands for the one cycle after the strobe
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rdata_q <= `GP_RST_ZERO;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // pad control; alternate function takes over the driver when selected
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            // shared pin hands its driver to its alternate function when selected
            if (alt_function_q[i])
            begin
                pad_out[i] = alt_out[i]; // R14
                pad_oe[i] = alt_oe[i]; // R13
            end
            else
            begin
                pad_out[i] = out_latch_reg_q[i]; // R07
                pad_oe[i] = dir_ctrl_reg_q[i]; // R06
            end
        end
        // absent pin is never driven
        pad_oe = pad_oe & `GP_PIN_MASK; // R01
        pad_out = pad_out & `GP_PIN_MASK;
        // latch bit gates the weak pull on an undriven pin
        pad_pull_en = ~pad_oe & out_latch_reg_q & `GP_PIN_MASK; // R11 R02
        pad_pull_up = pull_direction_sel_q; // R12
        pad_drive_hi = drive_strength_sel_q; // R10
    end

    // sampled level handed to the alternate functions on shared pins
    assign alt_in = edge_bus.level & `GP_ALT_MASK; // R13

    // flags that software lets through; absent pin never counts
    assign irq_pending = irq_stat_q & irq_en_q & PIN_MASK; // R16

    // level interrupt while any let-through flag stands
    assign irq = |irq_pending; // R16
    // stop mode only gates the wake line
    assign wake_req = stop_mode & irq; // R05

endmodule

// file: gp_bank_sva.sv
// concurrent checks on the gpio bank ports
`timescale 1ns/1ns
module gp_bank_sva
#(
    parameter int ADDR_W = 8
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_pull_en,
    input wire logic [7:0] pad_pull_up,
    input wire logic [7:0] pad_drive_hi,
    input wire logic [7:0] alt_in,
    input wire logic stop_mode,
    input wire logic irq,
    input wire logic wake_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // port values and register effects
    a_wake_from_irq: assert property (wake_req == (stop_mode && irq))
        else $error("wake request does not follow stop and irq");
    a_reset_inputs: assert property ($fell(sys_rst) |-> pad_oe == 8'h00 && pad_pull_en == 8'hFE)
        else $error("pins not pulled-up inputs after reset");
    a_pull_undriven: assert property ((pad_pull_en & pad_oe) == 8'h00)
        else $error("pull enabled on a driven pin");
    a_absent_pin: assert property (pad_oe[0] == 1'b0 && pad_pull_en[0] == 1'b0)
        else $error("absent pin is active");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    a_alt_in_pins: assert property ((alt_in & 8'h2F) == 8'h00)
        else $error("alternate input on a plain pin");
    a_dir_write: assert property (reg_wr && reg_addr == 8'h00 |=>
        (pad_oe & 8'h2E) == ($past(reg_wdata) & 8'h2E))
        else $error("direction write not applied");
    a_latch_drive: assert property (reg_wr && reg_addr == 8'h04 |=>
        ((pad_out ^ $past(reg_wdata)) & pad_oe & 8'h2E) == 8'h00)
        else $error("output pin does not show latch");
    a_pull_dir: assert property (reg_wr && reg_addr == 8'h10 |=>
        (pad_pull_up & 8'hFE) == ($past(reg_wdata) & 8'hFE))
        else $error("pull direction write not applied");
    a_drive_sel: assert property (reg_wr && reg_addr == 8'h0C |=>
        (pad_drive_hi & 8'hFE) == ($past(reg_wdata) & 8'hFE))
        else $error("drive strength write not applied");
endmodule

// file: gp_pad_model.sv
// external pads: resolves each pin from bank drive, outside drive and weak pull
`timescale 1ns/1ns
module gp_pad_model
(
    input wire logic clk,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_pull_en,
    input wire logic [7:0] pad_pull_up,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pad_in
);
    logic [7:0] float_q = 8'h00;
    // a floating pin flips each cycle so no stale level passes
    always @(posedge clk) float_q <= ~float_q;
    // wire level from all parties' enables
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                pad_pull_en[i] ? pad_pull_up[i] : float_q[i];
    end
endmodule

// file: gp_bank_tb.sv
// self-checking bench for the gpio bank
`timescale 1ns/1ns
module gp_bank_tb;
    import gp_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic stop_mode = 1'b0;
    logic [7:0] alt_out = 8'h00;
    logic [7:0] alt_oe = 8'h00;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] reg_rdata, pad_in, pad_out, pad_oe, pad_pull_en, pad_pull_up, pad_drive_hi;
    logic [7:0] alt_in;
    logic irq, wake_req;
    int error_cnt = 0;
    int checks_done = 0;
    logic [31:0] lfsr_q = 32'h000152FB;
    gp_byte_type ra [8] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24};
    gp_byte_type rv [8] = '{8'h00, 8'hFE, 8'h00, 8'hFE, 8'h00, 8'h00, 8'h00, 8'h00};
    gp_byte_type d, o, e, s;
    // clock
    always #10 clk = ~clk;
    gp_bank #(.ADDR_W(8)) dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en),
        .pad_pull_up(pad_pull_up), .pad_drive_hi(pad_drive_hi), .alt_out(alt_out),
        .alt_oe(alt_oe), .alt_in(alt_in), .stop_mode(stop_mode), .irq(irq), .wake_req(wake_req));
    gp_pad_model pads (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en),
        .pad_pull_up(pad_pull_up), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
    // random byte from the shift register
    function automatic gp_byte_type rnd();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q[7:0];
    endfunction
    // pin level expected from direction, latch and outside drive
    function automatic gp_byte_type exp_level(gp_byte_type dr, gp_byte_type lt, gp_byte_type ex);
        return ((dr & lt) | (~dr & ex)) & 8'hFE;
    endfunction
    // compares values that stood in the cycle before the current edge
    task automatic chk(input gp_byte_type got, input gp_byte_type exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input gp_byte_type a, input gp_byte_type v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input gp_byte_type a, input gp_byte_type exp, input bit do_chk);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        // read data stands in this cycle; taken at its closing edge
        @(posedge clk);
        if (do_chk)
            chk(reg_rdata, exp);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // watchdog
    initial
    begin
        #400000;
        error_cnt++;
        tally_and_finish();
    end
    // main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++)
            rd(ra[i], rv[i], 1);
        rd(8'h08, 8'hFE, 1);
        for (int i = 0; i < 8; i++)
        begin
            d = rnd();
            o = rnd();
            e = rnd();
            s = rnd();
            ext_en <= ~d & 8'hFE;
            ext_val <= e;
            wr(8'h00, d);
            wr(8'h04, o);
            wr(8'h0C, s);
            wr(8'h08, ~e);
            rd(8'h08, exp_level(d, o, e), 1);
            rd(8'h04, o & 8'hFE, 1);
            chk(pad_oe, d & 8'hFE);
            chk(pad_drive_hi, s & 8'hFE);
        end
        ext_en <= 8'h00;
        wr(8'h00, 8'h00);
        wr(8'h04, 8'hFE);
        s = rnd();
        wr(8'h10, s);
        repeat (3) @(posedge clk);
        rd(8'h08, s & 8'hFE, 1);
        chk(pad_pull_en, 8'hFE);
        wr(8'h04, 8'h00);
        @(posedge clk);
        chk(pad_pull_en, 8'h00);
        ext_en <= 8'hFE;
        ext_val <= 8'h00;
        wr(8'h14, 8'hAA);
        wr(8'h18, 8'hFE);
        repeat (4) @(posedge clk);
        rd(8'h1C, 8'h00, 0);
        chk({7'h00, irq}, 8'h00);
        ext_val <= 8'hFE;
        repeat (4) @(posedge clk);
        stop_mode <= 1'b1;
        @(posedge clk);
        chk({7'h00, irq}, 8'h01);
        chk({7'h00, wake_req}, 8'h01);
        rd(8'h1C, 8'hAA, 1);
        chk({7'h00, irq}, 8'h00);
        ext_val <= 8'h00;
        repeat (4) @(posedge clk);
        rd(8'h1C, 8'h54, 1);
        wr(8'h18, 8'h00);
        ext_val <= 8'hFE;
        repeat (4) @(posedge clk);
        chk({7'h00, wake_req}, 8'h00);
        wr(8'h18, 8'hFE);
        @(posedge clk);
        chk({7'h00, irq}, 8'h01);
        rd(8'h1C, 8'hAA, 1);
        stop_mode <= 1'b0;
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'hD0, 1);
        ext_en <= 8'hBE;
        alt_oe <= 8'h40;
        alt_out <= 8'h40;
        repeat (3) @(posedge clk);
        chk(pad_oe & 8'h40, 8'h40);
        chk(pad_out & 8'h40, 8'h40);
        chk(alt_in, 8'hD0);
        alt_out <= 8'h00;
        @(posedge clk);
        chk(pad_out & 8'h40, 8'h00);
        tally_and_finish();
    end
endmodule
bind gp_bank gp_bank_sva #(.ADDR_W(ADDR_W)) u_sva (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_en(pad_pull_en),
    .pad_pull_up(pad_pull_up), .pad_drive_hi(pad_drive_hi), .alt_in(alt_in),
    .stop_mode(stop_mode), .irq(irq), .wake_req(wake_req));
